// ---- shared/pfmo_pkg.sv ----
// Constants and types for the pin function override multiplexer.
// Assumes 36 lines: port A lines 0..22 at indices 0..22, port B lines 0..12 at 23..35.
package pfmo_pkg;

  localparam int NUM_LINES = 36;
  localparam int NUM_SEL = 8;
  localparam int NUM_TRACE = 11;
  localparam int PB_BASE = 23;

  // Line indices of fixed-function pins
  localparam int LINE_PA00 = 0;
  localparam int LINE_PA01 = 1;
  localparam int LINE_PA02 = 2;
  localparam int LINE_PA03 = 3;
  localparam int LINE_PA08 = 8;
  localparam int LINE_PA09 = 9;
  localparam int LINE_PA10 = 10;
  localparam int LINE_PA11 = 11;
  localparam int LINE_PA12 = 12;
  localparam int LINE_PA13 = 13;
  localparam int LINE_PA20 = 20;

  // Trace signal order: 0 event in, 1..6 data 5..0, 7 event out, 8 clock, 9..10 message 1..0
  localparam int TRACE_MAP1 [NUM_TRACE] = '{5, 10, 18, 17, 16, 15, 14, 4, 6, 7, 11};
  localparam int TRACE_MAP0 [NUM_TRACE] = '{31, 23, 27, 28, 26, 25, 32, 4, 24, 34, 35};
  localparam int TRACE_EVT_IN = 0;

  // Two-wire or open-drain capable selections, one mask per selection A..H
  localparam logic [NUM_LINES-1:0] TWI_ONE = 36'h1;
  localparam logic [NUM_LINES-1:0] TWI_MASK [NUM_SEL] = '{
    36'h0,
    (TWI_ONE << 5) | (TWI_ONE << 21),
    (TWI_ONE << 7),
    (TWI_ONE << 7) | (TWI_ONE << 17) | (TWI_ONE << 27) | (TWI_ONE << 28),
    36'h0,
    (TWI_ONE << 21) | (TWI_ONE << 27) | (TWI_ONE << 28),
    (TWI_ONE << 5) | (TWI_ONE << 27),
    36'h0
  };

  // Register byte offsets
  localparam logic [11:0] OFS_FUNC0 = 12'h000;
  localparam int NUM_FUNC_WORDS = 5;
  localparam logic [11:0] OFS_OSC = 12'h020;
  localparam logic [11:0] OFS_STATUS = 12'h024;
  localparam logic [11:0] OFS_OWNED_LO = 12'h028;
  localparam logic [11:0] OFS_OWNED_HI = 12'h02c;

  // Reset values
  localparam logic [3:0] FUNC_GPIO = 4'h8;
  localparam logic [2:0] OSC_RESET = 3'h0;

  // Oscillator control field positions
  localparam int OSC_MAIN_BIT = 0;
  localparam int OSC_SLOW_BIT = 1;
  localparam int OSC_ALT_BIT = 2;

  // Drive of one pad
  typedef struct packed {
    logic out;
    logic oe;
    logic twoWire;
    logic analog;
  } pfmo_pad_t;

endpackage

// ---- logic/pfmo_pin_mux.sv ----
// Pin function override multiplexer: GPIO, peripheral A..H and debug/oscillator overrides.
// Assumes pads resolve out/oe externally; debug units and APB master run on ref_clk.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pfmo_pin_mux (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [pfmo_pkg::NUM_LINES-1:0] gpioOut, // GPIO controller output
  input wire logic [pfmo_pkg::NUM_LINES-1:0] gpioOe, // GPIO controller enable
  input wire logic [pfmo_pkg::NUM_SEL-1:0][pfmo_pkg::NUM_LINES-1:0] periphOut, // Per selection
  input wire logic [pfmo_pkg::NUM_SEL-1:0][pfmo_pkg::NUM_LINES-1:0] periphOe, // Per selection
  output logic [pfmo_pkg::NUM_LINES-1:0] lineIn, // Synchronised pin levels to all users
  input wire logic traceEnable, // On-chip trace enabled
  input wire logic trace_pin_map_select, // Trace pin set select
  input wire logic [5:0] traceDataOut, // Trace data
  input wire logic [1:0] traceMsgOut, // Trace message framing
  input wire logic trace_clock_out, // Trace clock
  input wire logic trace_event_out, // Trace event output
  output logic traceEventIn, // Trace event input level
  input wire logic jtagEnable, // JTAG enabled
  input wire logic jtagTdo, // JTAG data out
  output logic jtagTck, // JTAG clock level
  output logic jtagTms, // JTAG mode select level
  output logic jtagTdi, // JTAG data in level
  input wire logic singleWireEnable, // Single-wire debug enabled
  input wire logic twoPinModeCmd, // Two-pin mode command received
  input wire logic debug_wire_data_out, // Two-pin mode data
  input wire logic debugWireDataOe, // Two-pin mode data enable
  input wire logic singleWireOut, // Single-wire data out
  input wire logic singleWireOe, // Single-wire data enable
  output logic singleWireIn, // Single-wire data in, high when idle
  input wire logic resetPinIn, // Reset pin level
  output logic resetPinOut, // Reset pin drive value
  output logic resetPinOe, // Reset pin drive enable
  output logic wakeIn_n, // Wake request, active low
  input wire logic [pfmo_pkg::NUM_LINES-1:0] pinIn, // Pad input levels
  output pfmo_pkg::pfmo_pad_t [pfmo_pkg::NUM_LINES-1:0] pad // Pad drive
);
  import pfmo_pkg::*;

  logic [NUM_LINES-1:0][3:0] funcSel_r;
  logic [2:0] oscCtl_r;
  logic [NUM_LINES-1:0] pinMeta_r;
  logic [NUM_LINES-1:0] pinSync_r;
  logic resetMeta_r;
  logic resetSync_r;
  logic [31:0] prdata_r;
  logic [31:0] rdData;
  logic rdHit;
  pfmo_pad_t [NUM_LINES-1:0] pad_r;
  pfmo_pad_t [NUM_LINES-1:0] pad_nxt;
  logic [NUM_LINES-1:0] owned;
  logic [NUM_TRACE-1:0] traceSig;
  logic dataOutOn;
  logic oscMainOn;
  logic oscSlowOn;
  logic oscAltOn;
  logic singleWireIn_r;
  logic wakeIn_r;
  logic traceEventIn_r;
  logic apbWrite;

  // Trace outputs in mapping order; slot 0 is the event input and never drives
  assign traceSig = {traceMsgOut[0], traceMsgOut[1], trace_clock_out, trace_event_out,
                     traceDataOut[0], traceDataOut[1], traceDataOut[2], traceDataOut[3],
                     traceDataOut[4], traceDataOut[5], 1'b0};

  // Override enables
  assign dataOutOn = singleWireEnable & twoPinModeCmd;
  assign oscMainOn = oscCtl_r[OSC_MAIN_BIT];
  assign oscSlowOn = oscCtl_r[OSC_SLOW_BIT] & ~oscCtl_r[OSC_ALT_BIT];
  assign oscAltOn = oscCtl_r[OSC_SLOW_BIT] & oscCtl_r[OSC_ALT_BIT];

  // Pin input synchronisers; first stage feeds only the second
  // Reset high, the idle level of the active-low wake and event pins, so no false edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
      resetMeta_r <= 1'b1;
      resetSync_r <= 1'b1;
    end else if (ce) begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
      resetMeta_r <= resetPinIn;
      resetSync_r <= resetMeta_r;
    end
  end

  // Every user sees the pin level, owner or not
  assign lineIn = pinSync_r;
  assign jtagTck = pinSync_r[LINE_PA00];
  assign jtagTms = pinSync_r[LINE_PA01];
  assign jtagTdi = pinSync_r[LINE_PA03];

  // Pad priority mux; later stages win, so the order below is the priority
  always_comb begin
    int line;
    line = 0;
    owned = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      // Base: GPIO or one peripheral selection
      if (funcSel_r[i][3]) begin
        pad_nxt[i].out = gpioOut[i];
        pad_nxt[i].oe = gpioOe[i];
        pad_nxt[i].twoWire = 1'b0;
      end else begin
        pad_nxt[i].out = periphOut[funcSel_r[i][2:0]][i];
        pad_nxt[i].oe = periphOe[funcSel_r[i][2:0]][i];
        pad_nxt[i].twoWire = TWI_MASK[funcSel_r[i][2:0]][i];
      end
      pad_nxt[i].analog = 1'b0;
    end
    // Trace system takes its set of lines
    if (traceEnable) begin
      for (int s = 0; s < NUM_TRACE; s++) begin
        line = trace_pin_map_select ? TRACE_MAP1[s] : TRACE_MAP0[s];
        pad_nxt[line].out = traceSig[s];
        pad_nxt[line].oe = (s != TRACE_EVT_IN);
        pad_nxt[line].twoWire = 1'b0;
        owned[line] = 1'b1;
      end
    end
    // Two-pin debug data out above trace
    if (dataOutOn) begin
      pad_nxt[LINE_PA00].out = debug_wire_data_out;
      pad_nxt[LINE_PA00].oe = debugWireDataOe;
      pad_nxt[LINE_PA00].twoWire = 1'b0;
      owned[LINE_PA00] = 1'b1;
    end
    // JTAG above data out; only the data-out line drives
    if (jtagEnable) begin
      for (int j = LINE_PA00; j <= LINE_PA03; j++) begin
        pad_nxt[j].out = (j == LINE_PA02) ? jtagTdo : 1'b0;
        pad_nxt[j].oe = (j == LINE_PA02);
        pad_nxt[j].twoWire = 1'b0;
        owned[j] = 1'b1;
      end
    end
    // Oscillators on top; pads go analog and undriven
    for (int k = 0; k < NUM_LINES; k++) begin
      if ((oscMainOn && (k == LINE_PA08 || k == LINE_PA09)) ||
          (oscSlowOn && (k == LINE_PA10 || k == LINE_PA12)) ||
          (oscAltOn && (k == LINE_PA13 || k == LINE_PA20))) begin
        pad_nxt[k].out = 1'b0;
        pad_nxt[k].oe = 1'b0;
        pad_nxt[k].twoWire = 1'b0;
        pad_nxt[k].analog = 1'b1;
        owned[k] = 1'b1;
      end
    end
  end

  // Registered pad drive; one cycle of latency after any source change
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pad_r <= '0;
    end else if (ce) begin
      pad_r <= pad_nxt;
    end
  end
  assign pad = pad_r;

  // Reset pin: single-wire data only once the interface is enabled
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b0;
      singleWireIn_r <= 1'b1;
    end else if (ce) begin
      resetPinOut <= singleWireEnable & singleWireOut;
      resetPinOe <= singleWireEnable & singleWireOe;
      singleWireIn_r <= singleWireEnable ? resetSync_r : 1'b1;
    end
  end
  assign singleWireIn = singleWireIn_r;

  // Wake and trace event inputs; wake ignores every selection
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wakeIn_r <= 1'b1;
      traceEventIn_r <= 1'b1;
    end else if (ce) begin
      wakeIn_r <= pinSync_r[LINE_PA11];
      traceEventIn_r <= pinSync_r[trace_pin_map_select ? TRACE_MAP1[TRACE_EVT_IN] :
                                                          TRACE_MAP0[TRACE_EVT_IN]];
    end
  end
  assign wakeIn_n = wakeIn_r;
  assign traceEventIn = traceEventIn_r;

  // APB read decode; any offset not listed answers with an error
  always_comb begin
    rdData = 32'h0;
    rdHit = 1'b1;
    if (paddr < OFS_FUNC0 + 12'(4 * NUM_FUNC_WORDS) && paddr[1:0] == 2'h0) begin
      for (int n = 0; n < 8; n++) begin
        if (int'(paddr[11:2]) * 8 + n < NUM_LINES) begin
          rdData[n*4 +: 4] = funcSel_r[int'(paddr[11:2]) * 8 + n];
        end
      end
    end else if (paddr == OFS_OSC) begin
      rdData[2:0] = oscCtl_r;
    end else if (paddr == OFS_STATUS) begin
      rdData[6:0] = {oscAltOn, oscSlowOn, oscMainOn, jtagEnable, dataOutOn,
                     trace_pin_map_select, traceEnable};
    end else if (paddr == OFS_OWNED_LO) begin
      rdData = owned[31:0];
    end else if (paddr == OFS_OWNED_HI) begin
      rdData[NUM_LINES-33:0] = owned[NUM_LINES-1:32];
    end else begin
      rdHit = 1'b0;
    end
  end

  // No wait states while enabled; a frozen block holds the access open
  assign pready = ce;
  assign pslverr = psel & penable & ~rdHit;
  assign apbWrite = psel & penable & pwrite & ce & rdHit;

  // Read data captured every selected cycle so it is valid in the access phase
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata_r <= 32'h0;
    end else if (ce && psel) begin
      prdata_r <= (rdHit && !pwrite) ? rdData : 32'h0;
    end
  end
  assign prdata = prdata_r;

  // Function selection registers, eight nibbles per word
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int r = 0; r < NUM_LINES; r++) begin
        funcSel_r[r] <= FUNC_GPIO;
      end
    end else if (apbWrite && paddr < OFS_FUNC0 + 12'(4 * NUM_FUNC_WORDS)) begin
      for (int n = 0; n < 8; n++) begin
        if (int'(paddr[11:2]) * 8 + n < NUM_LINES) begin
          funcSel_r[int'(paddr[11:2]) * 8 + n] <= pwdata[n*4 +: 4];
        end
      end
    end
  end

  // Oscillator pin control
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      oscCtl_r <= OSC_RESET;
    end else if (apbWrite && paddr == OFS_OSC) begin
      oscCtl_r <= pwdata[2:0];
    end
  end

endmodule

// ---- sim/pfmo_pin_mux_sva.sv ----
// Checker for the pin function override multiplexer, bound into the design.
// Assumes one clock domain, reset synchronous and active low.
`timescale 1ns/1ps
module pfmo_pin_mux_sva (
  input wire logic ref_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic [pfmo_pkg::NUM_LINES-1:0] pinIn, // Pad levels
  input wire pfmo_pkg::pfmo_pad_t [pfmo_pkg::NUM_LINES-1:0] pad, // Pad drive
  input wire logic [pfmo_pkg::NUM_LINES-1:0] lineIn, // Synced levels
  input wire logic wakeIn_n, // Wake, active low
  input wire logic resetPinOe, // Reset pin enable
  input wire logic singleWireEnable, // Single-wire on
  input wire logic twoPinModeCmd, // Two-pin command
  input wire logic jtagEnable, // JTAG on
  input wire logic jtagTdo, // JTAG data out
  input wire logic debug_wire_data_out, // Data-out value
  input wire logic debugWireDataOe, // Data-out enable
  input wire logic traceEnable, // Trace on
  input wire logic trace_pin_map_select, // Trace set
  input wire logic trace_clock_out, // Trace clock
  input wire logic trace_event_out // Trace event
);
  import pfmo_pkg::*;
  // State freezes with ce low, so each check starts from an enabled edge
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  jtag_tdo_a: assert property (
    ce && jtagEnable |=> pad[2].out == $past(jtagTdo) && pad[2].oe) else $error("tdo not routed");
  jtag_in_a: assert property (
    ce && jtagEnable |=> !(pad[0].oe || pad[1].oe || pad[3].oe)) else $error("jtag input driven");
  jtag_prio_a: assert property (
    ce && jtagEnable && singleWireEnable && twoPinModeCmd |=> !pad[0].oe)
    else $error("data-out beat jtag");
  dout_a: assert property (
    ce && singleWireEnable && twoPinModeCmd && !jtagEnable |=>
    pad[0].out == $past(debug_wire_data_out) && pad[0].oe == $past(debugWireDataOe))
    else $error("data-out not routed");
  swire_gate_a: assert property (
    ce && !singleWireEnable |=> !resetPinOe) else $error("reset pin driven");
  wake_path_a: assert property (
    (rst_b && ce) [*4] |-> wakeIn_n == $past(pinIn[11], 3)) else $error("wake not following");
  line_in_a: assert property (
    (rst_b && ce) [*3] |-> lineIn == $past(pinIn, 2)) else $error("line input lost");
  trace_set1_a: assert property (
    ce && traceEnable && trace_pin_map_select |=>
    pad[6].out == $past(trace_clock_out) && pad[6].oe) else $error("trace clock set 1");
  trace_set0_a: assert property (
    ce && traceEnable && !trace_pin_map_select |=> pad[24].out == $past(trace_clock_out))
    else $error("trace clock set 0");
  trace_evt_a: assert property (
    ce && traceEnable |=> pad[4].out == $past(trace_event_out)) else $error("trace event");
  trace_twi_a: assert property (
    ce && traceEnable && trace_pin_map_select |=> !pad[5].twoWire) else $error("two-wire kept");
endmodule
bind pfmo_pin_mux pfmo_pin_mux_sva chk (.*);

// ---- sim/pfmo_far_side.sv ----
// Model of the peripherals behind the mux: GPIO, selections A..H, data-out.
// Assumes fixed per-selection patterns; data-out enable follows the command.
`timescale 1ns/1ps
module pfmo_far_side (
  input wire logic ref_clk, // Clock
  input wire logic twoPinModeCmd, // Two-pin command seen
  output logic [pfmo_pkg::NUM_LINES-1:0] gpioOut, // GPIO value
  output logic [pfmo_pkg::NUM_LINES-1:0] gpioOe, // GPIO enable
  output logic [pfmo_pkg::NUM_SEL-1:0][pfmo_pkg::NUM_LINES-1:0] periphOut, // Sel value
  output logic [pfmo_pkg::NUM_SEL-1:0][pfmo_pkg::NUM_LINES-1:0] periphOe, // Sel enable
  output logic debug_wire_data_out, // Data-out value
  output logic debugWireDataOe // Data-out enable
);
  import pfmo_pkg::*;
  // Distinct pattern per selection so a wrong pick shows
  initial begin
    gpioOut = 36'h5a5a5a5a5;
    gpioOe = 36'h0f0f0f0f0;
    debug_wire_data_out = 1'b1;
    debugWireDataOe = 1'b0;
    for (int s = 0; s < NUM_SEL; s++) begin
      periphOut[s] = {4{9'(s * 73 + 5)}};
      periphOe[s] = ~periphOut[s];
    end
  end
  // Drives data out only once two-pin mode was commanded
  always @(posedge ref_clk) debugWireDataOe <= twoPinModeCmd;
endmodule

// ---- sim/pin_function_override_mux_test.sv ----
// Self-checking bench for the pin function override multiplexer.
// Copes with APB wait states (pready follows ce); assumes the far-side model.
`timescale 1ns/1ps
module pin_function_override_mux_test;
  import pfmo_pkg::*;
  logic ref_clk = 0;
  logic rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, traceEventIn, jtagTck, jtagTms, jtagTdi, singleWireIn;
  logic resetPinOut, resetPinOe, wakeIn_n, debug_wire_data_out, debugWireDataOe;
  logic traceEnable = 0, trace_pin_map_select = 0, trace_clock_out = 1, trace_event_out = 0;
  logic jtagEnable = 0, jtagTdo = 1, singleWireEnable = 0, twoPinModeCmd = 0;
  logic singleWireOut = 0, singleWireOe = 1, resetPinIn = 1;
  logic [5:0] traceDataOut = 6'h3f;
  logic [1:0] traceMsgOut = 2'h2;
  logic [NUM_LINES-1:0] gpioOut, gpioOe, lineIn, pinIn = 36'hfffffffff;
  logic [NUM_SEL-1:0][NUM_LINES-1:0] periphOut, periphOe;
  pfmo_pad_t [NUM_LINES-1:0] pad;
  localparam logic [31:0] W0 = 32'h23107654;
  int err_total = 0, checks = 0, s;
  pfmo_pin_mux dut (.*);
  pfmo_far_side far (.*);
  always #12.5 ref_clk = ~ref_clk;
  // APB cycle; waits for pready rather than assuming zero waits
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Lets edges pass, then steps off the edge to sample
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task cmp(input logic [35:0] g, input logic [35:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 60 cycles the tests need
  initial begin
    #200000;
    err_total++;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1;
    tick(3);
    for (int l = 0; l < NUM_LINES; l++) cmp({pad[l].out, pad[l].oe}, {gpioOut[l], gpioOe[l]});
    apb(0, OFS_FUNC0, 0);
    cmp(rd, 32'h88888888);
    apb(0, 12'h010, 0);
    cmp(rd, 32'h00008888);
    apb(0, 12'h100, 0);
    cmp({se, rd}, 33'h100000000);
    apb(1, OFS_FUNC0, W0);
    apb(0, OFS_FUNC0, 0);
    cmp(rd, W0);
    tick(1);
    for (int l = 0; l < 8; l++) begin
      s = W0[4*l +: 4];
      cmp({pad[l].out, pad[l].oe}, {periphOut[s][l], periphOe[s][l]});
      cmp(pad[l].twoWire, TWI_MASK[s][l]);
    end
    @(posedge ref_clk);
    {traceEnable, trace_pin_map_select, resetPinIn} <= 3'b110;
    tick(2);
    cmp({pad[6].out, pad[4].out, pad[5].oe, pad[5].twoWire}, 4'h8);
    cmp({singleWireIn, resetPinOe}, 2'h2);
    @(posedge ref_clk);
    trace_pin_map_select <= 0;
    tick(2);
    cmp({pad[24].out, pad[4].out, pad[6].out}, {2'h2, periphOut[3][6]});
    @(posedge ref_clk);
    trace_pin_map_select <= 1;
    apb(1, OFS_OSC, 32'h2);
    tick(2);
    cmp({pad[10].analog, pad[10].oe}, 2'h2);
    @(posedge ref_clk);
    {singleWireEnable, twoPinModeCmd, pinIn[11]} <= 3'b110;
    tick(4);
    cmp({pad[0].out, pad[0].oe}, 2'h3);
    cmp({singleWireIn, resetPinOe, wakeIn_n}, 3'h2);
    @(posedge ref_clk);
    {jtagEnable, pinIn[2]} <= 2'b10;
    tick(3);
    cmp({pad[0].oe, pad[2].out, pad[2].oe}, 3'h3);
    cmp(lineIn[2], 1'b0);
    cmp({jtagTck, jtagTms, jtagTdi, traceEventIn, resetPinOut}, 5'h1e);
    apb(0, OFS_STATUS, 0);
    cmp(rd, 32'h0000002f);
    apb(0, OFS_OWNED_LO, 0);
    cmp(rd, 32'h0007dcff);
    close_out;
  end
endmodule
